// >>> rtl/oag_defines.svh
`ifndef OAG_DEFINES_SVH
`define OAG_DEFINES_SVH
`define OAG_PREFIX_IND 8'h92
`define OAG_PAGE_MASK 16'h00FF
`define OAG_REL_BYTES 4'h1
`define OAG_SHORT_BYTES 4'h1
`define OAG_LONG_BYTES 4'h2
`define OAG_ZERO_BYTES 4'h0
`define OAG_IMM_BYTES 4'h1
`define OAG_BITREL_IND_BYTES 4'h3
`endif

// >>> rtl/oag_pkg.sv
package oag_pkg;
  typedef enum logic [3:0] {
    OAG_INHERENT = 4'h0,
    OAG_IMMEDIATE = 4'h1,
    OAG_DIR_SHORT = 4'h2,
    OAG_DIR_LONG = 4'h3,
    OAG_IDX_NONE = 4'h4,
    OAG_IDX_SHORT = 4'h5,
    OAG_IDX_LONG = 4'h6,
    OAG_IND_SHORT = 4'h7,
    OAG_IND_LONG = 4'h8,
    OAG_INDIDX_SHORT = 4'h9,
    OAG_INDIDX_LONG = 4'hA,
    OAG_REL_DIRECT = 4'hB,
    OAG_REL_INDIRECT = 4'hC,
    OAG_BIT_DIRECT = 4'hD,
    OAG_BIT_DIR_REL = 4'hE
  } oag_mode_t;
  typedef enum logic [2:0] {
    OAG_IDLE = 3'h0,
    OAG_PTR_LO = 3'h1,
    OAG_PTR_HI = 3'h2,
    OAG_DONE = 3'h3
  } oag_state_t;
endpackage

// >>> rtl/oag_adder.sv
module oag_adder
  import oag_pkg::*;
#(
  parameter int AW = 16
) (
  // operands
  input wire logic [AW-1:0] base,
  input wire logic [7:0] index,
  input wire logic sign_ext,
  // sum
  output logic [AW-1:0] sum
);
  logic [AW-1:0] ext;
  always_comb begin
    ext = {{(AW - 8){sign_ext & index[7]}}, index};
    sum = base + ext;
  end
endmodule

// >>> rtl/oag_core.sv
// Overview of operation
// - short direct uses one byte, page zero
// - long direct uses two-byte word address
// - indexed address is unsigned index plus offset
// - no-offset indexed uses index alone
// - short indexed adds byte offset, to 1FE
// - long indexed adds word offset
// - short indirect reads byte pointer, page zero
// - long indirect reads word pointer
// - indirect indexed adds pointer and index
// - relative target PC-128..PC+127 from next PC
// - inherent instructions are one byte
// - immediate instructions are two bytes
// - read-modify-write limited to page zero, except unprefixed relative
// - no-offset indexed adds 0 for X, 1 for Y
// - relative adds signed eight-bit displacement
// - prefix 92 turns direct into indirect
`include "oag_defines.svh"
module oag_core
  import oag_pkg::*;
(
  // clocking
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  // request
  input wire logic start,
  input wire oag_mode_t mode,
  input wire logic [7:0] prefix,
  input wire logic use_y,
  input wire logic rmw,
  input wire logic [7:0] byte1,
  input wire logic [7:0] byte2,
  input wire logic [7:0] idx_x,
  input wire logic [7:0] idx_y,
  input wire logic [15:0] next_pc,
  // pointer read
  output logic mem_rd,
  output logic [15:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [7:0] mem_data,
  // result
  output logic busy,
  output logic done,
  output logic [15:0] op_addr,
  output logic [7:0] imm_value,
  output logic is_imm,
  output logic [3:0] extra_bytes
);
  typedef struct packed {
    oag_state_t st;
    oag_mode_t md;
    logic ind;
    logic [7:0] idx;
    logic [7:0] ptr_a;
    logic [15:0] ptr;
    logic [15:0] pc;
    logic rmw;
    logic [15:0] addr;
    logic [7:0] imm;
    logic imm_f;
    logic [3:0] nb;
    logic done;
  } oag_regs_t;
  oag_regs_t r_q, r_d;
  logic [15:0] sum_o, base_i;
  logic [7:0] off_i;
  logic sx_i;
  logic ind_req;
  logic [7:0] idx_sel;
  logic [15:0] word12;
  logic word_ptr;
  logic add_idx;

  oag_adder #(.AW(16)) u_add (
    .base(base_i),
    .index(off_i),
    .sign_ext(sx_i),
    .sum(sum_o)
  );

  ////////////////////////////////////////////////////////////////
  always_comb begin
    ind_req = (prefix == `OAG_PREFIX_IND);
    idx_sel = use_y ? idx_y : idx_x;
    word12 = {byte1, byte2};
    word_ptr = (r_q.md == OAG_IND_LONG) || (r_q.md == OAG_INDIDX_LONG);
    add_idx = (r_q.md == OAG_INDIDX_SHORT) || (r_q.md == OAG_INDIDX_LONG) || (r_q.md == OAG_IDX_SHORT);
    base_i = 16'h0000;
    off_i = 8'h00;
    sx_i = 1'b0;
    if (r_q.st == OAG_DONE) begin
      base_i = r_q.ptr;
      off_i = add_idx ? r_q.idx : 8'h00;
      if (r_q.md == OAG_REL_INDIRECT || r_q.md == OAG_BIT_DIR_REL) begin
        base_i = r_q.pc;
        off_i = r_q.ptr[7:0];
        sx_i = 1'b1;
      end
    end else begin
      case (mode)
        OAG_IDX_SHORT: begin
          base_i = {8'h00, byte1};
          off_i = idx_sel;
        end
        OAG_IDX_LONG: begin
          base_i = word12;
          off_i = idx_sel;
        end
        OAG_REL_DIRECT: begin
          base_i = next_pc;
          off_i = byte1;
          sx_i = 1'b1;
        end
        default: begin
          base_i = 16'h0000;
          off_i = 8'h00;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  always_comb begin
    r_d = r_q;
    r_d.done = 1'b0;
    mem_rd = 1'b0;
    mem_addr = 16'h0000;
    case (r_q.st)
      OAG_IDLE: begin
        if (start) begin
          r_d.md = mode;
          r_d.idx = idx_sel;
          r_d.pc = next_pc;
          r_d.rmw = rmw;
          r_d.ind = ind_req;
          r_d.ptr_a = byte1;
          r_d.ptr = 16'h0000;
          r_d.imm_f = 1'b0;
          r_d.imm = 8'h00;
          r_d.done = 1'b1;
          r_d.addr = 16'h0000;
          case (mode)
            OAG_INHERENT: r_d.nb = `OAG_ZERO_BYTES;
            OAG_IMMEDIATE: begin
              r_d.nb = `OAG_IMM_BYTES;
              r_d.imm = byte1;
              r_d.imm_f = 1'b1;
            end
            OAG_DIR_SHORT, OAG_BIT_DIRECT: begin
              r_d.nb = ind_req ? `OAG_LONG_BYTES : `OAG_SHORT_BYTES;
              r_d.addr = {8'h00, byte1};
            end
            OAG_DIR_LONG: begin
              r_d.nb = `OAG_LONG_BYTES;
              r_d.addr = rmw ? (word12 & `OAG_PAGE_MASK) : word12;
            end
            OAG_IDX_NONE: begin
              r_d.nb = use_y ? `OAG_SHORT_BYTES : `OAG_ZERO_BYTES;
              r_d.addr = {8'h00, idx_sel};
            end
            OAG_IDX_SHORT: begin
              r_d.nb = ind_req ? `OAG_LONG_BYTES : `OAG_SHORT_BYTES;
              r_d.addr = rmw ? (sum_o & `OAG_PAGE_MASK) : sum_o;
            end
            OAG_IDX_LONG: begin
              r_d.nb = `OAG_LONG_BYTES;
              r_d.addr = rmw ? (sum_o & `OAG_PAGE_MASK) : sum_o;
            end
            OAG_REL_DIRECT: begin
              r_d.nb = ind_req ? `OAG_LONG_BYTES : `OAG_REL_BYTES;
              r_d.addr = sum_o;
            end
            OAG_BIT_DIR_REL: r_d.nb = ind_req ? `OAG_BITREL_IND_BYTES : `OAG_LONG_BYTES;
            default: r_d.nb = `OAG_LONG_BYTES;
          endcase
          // prefix turns direct, short and long indexed (X or Y) and relative forms into pointer fetches
          if (ind_req) begin
            case (mode)
              OAG_DIR_SHORT, OAG_BIT_DIRECT: r_d.md = OAG_IND_SHORT;
              OAG_IDX_SHORT: r_d.md = OAG_INDIDX_SHORT;
              OAG_DIR_LONG: r_d.md = OAG_IND_LONG;
              OAG_IDX_LONG: r_d.md = OAG_INDIDX_LONG;
              OAG_REL_DIRECT: r_d.md = OAG_REL_INDIRECT;
              default: r_d.md = mode;
            endcase
          end
          // bit-relative needs the target later; its offset is byte2
          if (mode == OAG_BIT_DIR_REL && !ind_req) begin
            r_d.addr = {8'h00, byte1};
            r_d.ptr = {8'h00, byte2};
            r_d.st = OAG_DONE;
            r_d.done = 1'b0;
          end
          case (r_d.md)
            OAG_IND_SHORT, OAG_IND_LONG, OAG_INDIDX_SHORT, OAG_INDIDX_LONG,
            OAG_REL_INDIRECT: begin
              r_d.st = OAG_PTR_LO;
              r_d.done = 1'b0;
            end
            default: ;
          endcase
          if (mode == OAG_BIT_DIR_REL && ind_req) begin
            r_d.st = OAG_PTR_LO;
            r_d.done = 1'b0;
          end
        end
      end
      OAG_PTR_LO: begin
        mem_rd = 1'b1;
        mem_addr = {8'h00, r_q.ptr_a};
        if (mem_ack) begin
          if (word_ptr) begin
            r_d.ptr = {mem_data, 8'h00};
            r_d.st = OAG_PTR_HI;
          end else begin
            r_d.ptr = {8'h00, mem_data};
            r_d.st = OAG_DONE;
          end
        end
      end
      OAG_PTR_HI: begin
        mem_rd = 1'b1;
        mem_addr = {8'h00, r_q.ptr_a} + 16'h0001;
        if (mem_ack) begin
          r_d.ptr = {r_q.ptr[15:8], mem_data};
          r_d.st = OAG_DONE;
        end
      end
      OAG_DONE: begin
        r_d.addr = sum_o;
        if (r_q.md == OAG_BIT_DIRECT || (r_q.md == OAG_BIT_DIR_REL && r_q.ind)) begin
          r_d.addr = r_q.ptr;
        end
        if (r_q.rmw) begin
          r_d.addr = sum_o & `OAG_PAGE_MASK;
        end
        r_d.done = 1'b1;
        r_d.st = OAG_IDLE;
      end
      default: r_d.st = OAG_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      r_q <= '0;
    end else if (clk_en) begin
      r_q <= r_d;
    end
  end

  always_comb begin
    busy = (r_q.st != OAG_IDLE);
    done = r_q.done;
    op_addr = r_q.addr;
    imm_value = r_q.imm;
    is_imm = r_q.imm_f;
    extra_bytes = r_q.nb;
  end

  ////////////////////////////////////////////////////////////////
  sequence s_req_dir;
    start && !busy && mode == OAG_DIR_SHORT && prefix != `OAG_PREFIX_IND && clk_en;
  endsequence

  AST_DIR_SHORT: assert property (@(posedge clock) disable iff (sys_rst)
    s_req_dir |=> done && op_addr == {8'h00, $past(byte1)} && extra_bytes == `OAG_SHORT_BYTES)
    else $error("short direct address wrong");
  AST_DIR_LONG: assert property (@(posedge clock) disable iff (sys_rst)
    start && !busy && clk_en && mode == OAG_DIR_LONG && !rmw
    |=> op_addr == {$past(byte1), $past(byte2)} && extra_bytes == `OAG_LONG_BYTES)
    else $error("long direct address wrong");
  AST_IDX_SHORT: assert property (@(posedge clock) disable iff (sys_rst)
    start && !busy && clk_en && mode == OAG_IDX_SHORT && !rmw && prefix != `OAG_PREFIX_IND
    |=> op_addr == {8'h00, $past(byte1)} + {8'h00, $past(use_y ? idx_y : idx_x)})
    else $error("short indexed sum wrong");
  AST_IDX_NONE: assert property (@(posedge clock) disable iff (sys_rst)
    start && !busy && clk_en && mode == OAG_IDX_NONE
    |=> extra_bytes == ($past(use_y) ? `OAG_SHORT_BYTES : `OAG_ZERO_BYTES) && op_addr[15:8] == 8'h00)
    else $error("no-offset indexed length wrong");
  AST_INHERENT: assert property (@(posedge clock) disable iff (sys_rst)
    start && !busy && clk_en && mode == OAG_INHERENT |=> done && extra_bytes == `OAG_ZERO_BYTES)
    else $error("inherent length wrong");
  AST_IMM: assert property (@(posedge clock) disable iff (sys_rst)
    start && !busy && clk_en && mode == OAG_IMMEDIATE |=> is_imm && imm_value == $past(byte1))
    else $error("immediate value wrong");
  AST_REL: assert property (@(posedge clock) disable iff (sys_rst)
    start && !busy && clk_en && mode == OAG_REL_DIRECT && prefix != `OAG_PREFIX_IND
    |=> op_addr == $past(next_pc) + {{8{$past(byte1[7])}}, $past(byte1)})
    else $error("relative target wrong");
  AST_PREFIX: assert property (@(posedge clock) disable iff (sys_rst)
    start && !busy && clk_en && mode == OAG_DIR_SHORT && prefix == `OAG_PREFIX_IND
    |=> mem_rd && mem_addr == {8'h00, $past(byte1)})
    else $error("prefix did not start pointer read");
  AST_RMW: assert property (@(posedge clock) disable iff (sys_rst)
    done && r_q.rmw |-> op_addr[15:8] == 8'h00)
    else $error("rmw address left page zero");

  sequence s_ptr_word;
    r_q.st == OAG_PTR_LO && word_ptr && mem_ack && clk_en;
  endsequence

  AST_IDX_LONG: assert property (@(posedge clock) disable iff (sys_rst)
    start && !busy && clk_en && mode == OAG_IDX_LONG && !rmw && prefix != `OAG_PREFIX_IND
    |=> op_addr == {$past(byte1), $past(byte2)} + {8'h00, $past(use_y ? idx_y : idx_x)})
    else $error("long indexed sum wrong");
  AST_PTR_HI: assert property (@(posedge clock) disable iff (sys_rst)
    s_ptr_word |=> mem_rd && mem_addr == $past(mem_addr) + 16'h0001)
    else $error("word pointer low byte address wrong");
  AST_IND_SUM: assert property (@(posedge clock) disable iff (sys_rst)
    r_q.st == OAG_DONE && clk_en && add_idx && !r_q.rmw
    |=> done && op_addr == $past(r_q.ptr) + {8'h00, $past(r_q.idx)})
    else $error("indirect indexed sum wrong");
endmodule

// >>> tb/oag_tb.sv
module tb
  import oag_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic start = 1'b0;
  logic use_y = 1'b0;
  logic rmw = 1'b0;
  logic mem_ack = 1'b0;
  oag_mode_t mode = OAG_INHERENT;
  logic [7:0] prefix = 8'h00;
  logic [7:0] byte1 = 8'h00;
  logic [7:0] byte2 = 8'h00;
  logic [7:0] idx_x = 8'hFF;
  logic [7:0] idx_y = 8'h3C;
  logic [7:0] mem_data = 8'h00;
  logic [15:0] next_pc = 16'h1000;
  logic mem_rd;
  logic busy;
  logic done;
  logic is_imm;
  logic [15:0] mem_addr;
  logic [15:0] op_addr;
  logic [7:0] imm_value;
  logic [3:0] extra_bytes;
  logic [7:0] pmem [0:255];
  logic [15:0] rd_q [$];
  logic [15:0] rd_n;
  int error_cnt = 0;
  int n_compared = 0;

  always #2.5 clock = ~clock;

  oag_core dut (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .start(start), .mode(mode),
    .prefix(prefix), .use_y(use_y), .rmw(rmw), .byte1(byte1), .byte2(byte2), .idx_x(idx_x),
    .idx_y(idx_y), .next_pc(next_pc), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_ack(mem_ack),
    .mem_data(mem_data), .busy(busy), .done(done), .op_addr(op_addr), .imm_value(imm_value),
    .is_imm(is_imm), .extra_bytes(extra_bytes));

  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task results;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // serve pointer reads until done, then expect done to drop
  task run;
    logic [15:0] a;
    rd_n = 16'h0000;
    rd_q.delete();
    for (int k = 0; k < 40; k++) begin
      @(negedge clock);
      if (done === 1'b1) begin
        @(negedge clock);
        chk(16'(done), 16'h0000);
        return;
      end
      if (mem_rd === 1'b1) begin
        chk(16'(busy), 16'h0001);
        a = mem_addr;
        rd_q.push_back(a);
        rd_n++;
        @(posedge clock);
        mem_ack <= 1'b1;
        mem_data <= pmem[a[7:0]];
        @(posedge clock);
        mem_ack <= 1'b0;
        mem_data <= ~pmem[a[7:0]];
      end
    end
    error_cnt++;
    $display("Error at %0t: no completion", $time);
  endtask

  task op_na(input oag_mode_t m, input logic [7:0] pf, input logic y, input logic rm,
             input logic [7:0] b1, input logic [7:0] b2, input logic [15:0] nr);
    @(posedge clock);
    start <= 1'b1;
    mode <= m;
    prefix <= pf;
    use_y <= y;
    rmw <= rm;
    byte1 <= b1;
    byte2 <= b2;
    @(posedge clock);
    start <= 1'b0;
    run();
    chk(rd_n, nr);
  endtask

  task op(input oag_mode_t m, input logic [7:0] pf, input logic y, input logic rm,
          input logic [7:0] b1, input logic [7:0] b2, input logic [15:0] ea, input logic [15:0] nr);
    op_na(m, pf, y, rm, b1, b2, nr);
    chk(op_addr, ea);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task t_reset;
    @(negedge clock);
    chk(16'({busy, done, mem_rd, is_imm, extra_bytes}), 16'h0000);
    chk(op_addr, 16'h0000);
  endtask

  task t_direct;
    op(OAG_DIR_SHORT, 8'h00, 1'b0, 1'b0, 8'hFF, 8'h55, 16'h00FF, 16'h0000);
    chk(16'(extra_bytes), 16'h0001);
    op(OAG_DIR_LONG, 8'h00, 1'b0, 1'b0, 8'h12, 8'h34, 16'h1234, 16'h0000);
    chk(16'(extra_bytes), 16'h0002);
    op(OAG_DIR_LONG, 8'h00, 1'b0, 1'b1, 8'h12, 8'h34, 16'h0034, 16'h0000);
  endtask

  task t_indexed;
    op(OAG_IDX_NONE, 8'h00, 1'b0, 1'b0, 8'h77, 8'h00, 16'h00FF, 16'h0000);
    chk(16'(extra_bytes), 16'h0000);
    op(OAG_IDX_NONE, 8'h00, 1'b1, 1'b0, 8'h77, 8'h00, 16'h003C, 16'h0000);
    chk(16'(extra_bytes), 16'h0001);
    op(OAG_IDX_SHORT, 8'h00, 1'b0, 1'b0, 8'hFF, 8'h00, 16'h01FE, 16'h0000);
    chk(16'(extra_bytes), 16'h0001);
    op(OAG_IDX_SHORT, 8'h00, 1'b0, 1'b1, 8'hFF, 8'h00, 16'h00FE, 16'h0000);
    op(OAG_IDX_LONG, 8'h00, 1'b1, 1'b0, 8'h12, 8'hF0, 16'h132C, 16'h0000);
    chk(16'(extra_bytes), 16'h0002);
  endtask

  task t_indirect;
    pmem[8'h10] = 8'hAB;
    pmem[8'h11] = 8'hCD;
    op(OAG_IND_SHORT, 8'h00, 1'b0, 1'b0, 8'h10, 8'h00, 16'h00AB, 16'h0001);
    chk(rd_q[0], 16'h0010);
    op(OAG_IND_LONG, 8'h00, 1'b0, 1'b0, 8'h10, 8'h00, 16'hABCD, 16'h0002);
    chk(rd_q[1], 16'h0011);
    op(OAG_INDIDX_SHORT, 8'h00, 1'b0, 1'b0, 8'h10, 8'h00, 16'h01AA, 16'h0001);
    op(OAG_INDIDX_LONG, 8'h00, 1'b1, 1'b0, 8'h10, 8'h00, 16'hAC09, 16'h0002);
    op(OAG_DIR_SHORT, 8'h92, 1'b0, 1'b0, 8'h11, 8'h00, 16'h00CD, 16'h0001);
    chk(16'(extra_bytes), 16'h0002);
    op(OAG_IDX_SHORT, 8'h92, 1'b0, 1'b0, 8'h10, 8'h00, 16'h01AA, 16'h0001);
    op(OAG_DIR_LONG, 8'h92, 1'b0, 1'b0, 8'h10, 8'h00, 16'hABCD, 16'h0002);
    op(OAG_IDX_LONG, 8'h92, 1'b0, 1'b0, 8'h10, 8'h00, 16'hACCC, 16'h0002);
    op(OAG_INDIDX_SHORT, 8'h00, 1'b0, 1'b1, 8'h10, 8'h00, 16'h00AA, 16'h0001);
  endtask

  task t_relative;
    pmem[8'h12] = 8'hFE;
    op(OAG_REL_DIRECT, 8'h00, 1'b0, 1'b0, 8'h80, 8'h00, 16'h0F80, 16'h0000);
    chk(16'(extra_bytes), 16'h0001);
    op(OAG_REL_DIRECT, 8'h00, 1'b0, 1'b0, 8'h7F, 8'h00, 16'h107F, 16'h0000);
    op(OAG_REL_INDIRECT, 8'h00, 1'b0, 1'b0, 8'h12, 8'h00, 16'h0FFE, 16'h0001);
    op(OAG_REL_DIRECT, 8'h92, 1'b0, 1'b0, 8'h12, 8'h00, 16'h0FFE, 16'h0001);
    chk(16'(extra_bytes), 16'h0002);
  endtask

  task t_bit;
    op(OAG_BIT_DIRECT, 8'h00, 1'b0, 1'b0, 8'h44, 8'h00, 16'h0044, 16'h0000);
    chk(16'(extra_bytes), 16'h0001);
    op(OAG_BIT_DIRECT, 8'h92, 1'b0, 1'b0, 8'h10, 8'h00, 16'h00AB, 16'h0001);
    chk(16'(extra_bytes), 16'h0002);
    op(OAG_BIT_DIR_REL, 8'h00, 1'b0, 1'b0, 8'h44, 8'hFC, 16'h0FFC, 16'h0000);
    chk(16'(extra_bytes), 16'h0002);
    op(OAG_BIT_DIR_REL, 8'h92, 1'b0, 1'b0, 8'h12, 8'hFC, 16'h00FE, 16'h0001);
    chk(16'(extra_bytes), 16'h0003);
  endtask

  task t_inh_imm;
    op_na(OAG_INHERENT, 8'h00, 1'b0, 1'b0, 8'h33, 8'h44, 16'h0000);
    chk(16'(extra_bytes), 16'h0000);
    op_na(OAG_IMMEDIATE, 8'h00, 1'b0, 1'b0, 8'h5A, 8'h44, 16'h0000);
    chk({7'h00, is_imm, imm_value}, 16'h015A);
    chk(16'(extra_bytes), 16'h0001);
  endtask

  // request held while frozen must wait for clk_en
  task t_freeze;
    @(posedge clock);
    clk_en <= 1'b0;
    start <= 1'b1;
    mode <= OAG_DIR_SHORT;
    prefix <= 8'h00;
    rmw <= 1'b0;
    byte1 <= 8'h77;
    repeat (3) @(negedge clock);
    chk({15'h0000, done}, 16'h0000);
    @(posedge clock);
    clk_en <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    run();
    chk(op_addr, 16'h0077);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset();
    t_direct();
    t_indexed();
    t_indirect();
    t_relative();
    t_bit();
    t_inh_imm();
    t_freeze();
    results();
  end

  initial begin
    #20000;
    error_cnt++;
    $display("Error at %0t: watchdog expired", $time);
    results();
  end
endmodule
